/* hw/spsl_pkg.sv */
package spsl_pkg;
  // Register byte offsets on the AXI4-Lite slave.
  localparam logic [7:0] ADDR_ESTOP_TRQ = 8'h00;
  localparam logic [7:0] ADDR_OVLD_LVL = 8'h04;
  localparam logic [7:0] ADDR_OVSPD_LVL = 8'h08;
  localparam logic [7:0] ADDR_CTRL = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_EFF_TRQ = 8'h14;
  localparam logic [7:0] ADDR_EFF_OVSPD = 8'h18;
  localparam logic [7:0] ADDR_EFF_OVLD = 8'h1c;
  // Setting ranges and fixed levels.
  localparam logic [15:0] ESTOP_TRQ_MAX = 16'h01f4;
  localparam logic [15:0] OVLD_DEFAULT = 16'h0073;
  localparam logic [15:0] OVSPD_MAX = 16'h4e20;
  localparam logic [15:0] STOP_SPEED = 16'h001e;
  localparam logic [3:0] ACTION_SEVEN = 4'h7;
  // Field positions in the control and status registers.
  localparam int CTRL_ACT_LSB = 0;
  localparam int ST_STATE_LSB = 0;
  localparam int ST_OVSPD_BIT = 4;
  localparam int ST_OVLD_BIT = 5;
  localparam int ST_CLR_BIT = 6;
  localparam int ST_DB_BIT = 7;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    SPSL_RUN,
    SPSL_DECEL,
    SPSL_FREE,
    SPSL_STOPPED
  } spsl_state_e;

  // Drive command bundle sent toward the power stage.
  typedef struct packed {
    logic [15:0] torque_limit;
    logic freerun;
    logic dynamic_braking;
    logic dev_clear;
    logic estop_decel;
  } spsl_drive_s;
endpackage

/* hw/spsl_top.sv */
// Function
// - Hold e-stop torque limit 0..500 percent, apply during e-stop deceleration.
// - E-stop torque setting zero uses the normal torque limit instead.
// - Compare effective torque to overload level; zero selects 115 percent.
// - Clamp nonzero overload level to at most 115 percent.
// - Raise over-speed fault above level 0..20000; zero uses motor's level.
// - Internal over-speed threshold never exceeds the motor's own level.
// - Deceleration ends below 30 r/min, then enter post-stop state.
// - Action 7, e-stop alarm: e-stop decel, then free-run, clearing deviation.
// - Action 7, other alarm: free-run with braking off, clearing deviation.
// - While clearing, stop position command and track feedback position.
module spsl_top
  import spsl_pkg::*;
#(
  parameter int SPW = 16
) (
  input wire logic I_REF_CLK,
  input wire logic I_RST_N,
  input wire logic [7:0] I_AWADDR,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  input wire logic I_WVALID,
  output logic O_WREADY,
  output logic [1:0] O_BRESP,
  output logic O_BVALID,
  input wire logic I_BREADY,
  input wire logic [7:0] I_ARADDR,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  output logic O_RVALID,
  input wire logic I_RREADY,
  input wire logic [SPW-1:0] I_MOTOR_SPEED,
  input wire logic [15:0] I_EFF_TORQUE,
  input wire logic [15:0] I_NORMAL_TORQUE_LIMIT,
  input wire logic [SPW-1:0] I_MOTOR_OVERSPEED,
  input wire logic I_ALARM,
  input wire logic I_ALARM_ESTOP,
  input wire logic [31:0] I_FEEDBACK_POS,
  input wire logic [31:0] I_POS_CMD_STEP,
  output logic [15:0] O_TORQUE_LIMIT,
  output logic O_FREERUN,
  output logic O_DYNAMIC_BRAKING,
  output logic O_DEV_CLEAR,
  output logic O_ESTOP_DECEL,
  output logic O_OVERSPEED_FAULT,
  output logic O_OVERLOAD_DET,
  output logic [31:0] O_POS_CMD
);

  logic [15:0] estop_torque_limit_q;
  logic [15:0] overload_level_q;
  logic [15:0] overspeed_level_q;
  logic [3:0] action_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic aw_have_q;
  logic w_have_q;
  logic [31:0] rdata_d;
  logic rd_ok;
  logic wr_go;
  logic [15:0] eff_ovld;
  logic [SPW-1:0] eff_ovspd;
  logic [15:0] estop_trq_eff;
  spsl_state_e state_q;
  spsl_drive_s drive_q;
  spsl_drive_s drive_d;
  logic ovspd_q;
  logic ovld_q;
  logic [31:0] pos_cmd_q;

  // Write address and data are caught independently, in either order.
  assign O_AWREADY = !aw_have_q;
  assign O_WREADY = !w_have_q;
  assign wr_go = aw_have_q && w_have_q && !O_BVALID;

  // Holds the write channels until both halves are present.
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
    end else begin
      if (I_AWVALID && O_AWREADY) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= I_AWADDR;
      end else if (wr_go) begin
        aw_have_q <= 1'b0;
      end
      if (I_WVALID && O_WREADY) begin
        w_have_q <= 1'b1;
        w_data_q <= I_WDATA;
      end else if (wr_go) begin
        w_have_q <= 1'b0;
      end
    end
  end

  // Settings written by software; over-range e-stop torque and over-speed values are saturated at the top.
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      estop_torque_limit_q <= 16'h0000;
      overload_level_q <= 16'h0000;
      overspeed_level_q <= 16'h0000;
      action_q <= 4'h0;
      O_BVALID <= 1'b0;
      O_BRESP <= RESP_OKAY;
    end else begin
      if (wr_go) begin
        O_BVALID <= 1'b1;
        O_BRESP <= RESP_OKAY;
        case (aw_addr_q)
          ADDR_ESTOP_TRQ: begin
            if (w_data_q[15:0] > ESTOP_TRQ_MAX) begin
              estop_torque_limit_q <= ESTOP_TRQ_MAX;
            end else begin
              estop_torque_limit_q <= w_data_q[15:0];
            end
          end
          ADDR_OVLD_LVL: overload_level_q <= w_data_q[15:0];
          ADDR_OVSPD_LVL: begin
            if (w_data_q[15:0] > OVSPD_MAX) begin
              overspeed_level_q <= OVSPD_MAX;
            end else begin
              overspeed_level_q <= w_data_q[15:0];
            end
          end
          ADDR_CTRL: action_q <= w_data_q[CTRL_ACT_LSB +: 4];
          default: O_BRESP <= RESP_SLVERR;
        endcase
      end else if (O_BVALID && I_BREADY) begin
        O_BVALID <= 1'b0;
      end
    end
  end

  // Read mux over settings and live state.
  always_comb begin
    rdata_d = 32'h0000_0000;
    rd_ok = 1'b1;
    case (I_ARADDR)
      ADDR_ESTOP_TRQ: rdata_d[15:0] = estop_torque_limit_q;
      ADDR_OVLD_LVL: rdata_d[15:0] = overload_level_q;
      ADDR_OVSPD_LVL: rdata_d[15:0] = overspeed_level_q;
      ADDR_CTRL: rdata_d[CTRL_ACT_LSB +: 4] = action_q;
      ADDR_STATUS: begin
        rdata_d[ST_STATE_LSB +: 2] = state_q;
        rdata_d[ST_OVSPD_BIT] = ovspd_q;
        rdata_d[ST_OVLD_BIT] = ovld_q;
        rdata_d[ST_CLR_BIT] = drive_q.dev_clear;
        rdata_d[ST_DB_BIT] = drive_q.dynamic_braking;
      end
      ADDR_EFF_TRQ: rdata_d[15:0] = estop_trq_eff;
      ADDR_EFF_OVSPD: rdata_d[SPW-1:0] = eff_ovspd;
      ADDR_EFF_OVLD: rdata_d[15:0] = eff_ovld;
      default: rd_ok = 1'b0;
    endcase
  end

  assign O_ARREADY = !O_RVALID;

  // Read answer one cycle after the address is taken.
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      O_RVALID <= 1'b0;
      O_RDATA <= 32'h0000_0000;
      O_RRESP <= RESP_OKAY;
    end else if (I_ARVALID && O_ARREADY) begin
      O_RVALID <= 1'b1;
      O_RDATA <= rdata_d;
      O_RRESP <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (O_RVALID && I_RREADY) begin
      O_RVALID <= 1'b0;
    end
  end

  // Effective thresholds derived from the settings.
  always_comb begin
    estop_trq_eff = (estop_torque_limit_q == 16'h0000) ? I_NORMAL_TORQUE_LIMIT
                                                       : estop_torque_limit_q;
    if (overload_level_q == 16'h0000 || overload_level_q > OVLD_DEFAULT) begin
      eff_ovld = OVLD_DEFAULT;
    end else begin
      eff_ovld = overload_level_q;
    end
    if (overspeed_level_q == 16'h0000 || SPW'(overspeed_level_q) > I_MOTOR_OVERSPEED) begin
      eff_ovspd = I_MOTOR_OVERSPEED;
    end else begin
      eff_ovspd = SPW'(overspeed_level_q);
    end
  end

  // Protection detectors registered each cycle.
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      ovspd_q <= 1'b0;
      ovld_q <= 1'b0;
    end else begin
      ovspd_q <= I_MOTOR_SPEED > eff_ovspd;
      ovld_q <= I_EFF_TORQUE > eff_ovld;
    end
  end

  // Stop sequence for alarm action seven.
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      state_q <= SPSL_RUN;
    end else begin
      case (state_q)
        SPSL_RUN: begin
          if (I_ALARM && action_q == ACTION_SEVEN) begin
            state_q <= I_ALARM_ESTOP ? SPSL_DECEL : SPSL_FREE;
          end
        end
        SPSL_DECEL: begin
          if (I_MOTOR_SPEED < SPW'(STOP_SPEED)) begin
            state_q <= SPSL_STOPPED;
          end
        end
        SPSL_FREE: begin
          if (I_MOTOR_SPEED < SPW'(STOP_SPEED)) begin
            state_q <= SPSL_STOPPED;
          end
        end
        SPSL_STOPPED: begin
          if (!I_ALARM) begin
            state_q <= SPSL_RUN;
          end
        end
        default: state_q <= SPSL_RUN;
      endcase
    end
  end

  // Drive bundle for each phase of the stop.
  always_comb begin
    drive_d = '0;
    drive_d.torque_limit = I_NORMAL_TORQUE_LIMIT;
    case (state_q)
      SPSL_DECEL: begin
        drive_d.torque_limit = estop_trq_eff;
        drive_d.estop_decel = 1'b1;
        drive_d.dev_clear = 1'b1;
      end
      SPSL_FREE, SPSL_STOPPED: begin
        drive_d.freerun = 1'b1;
        drive_d.dev_clear = 1'b1;
      end
      default: drive_d.dynamic_braking = 1'b0;
    endcase
  end

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      drive_q <= '0;
    end else begin
      drive_q <= drive_d;
    end
  end

  // Position command generator; follows feedback while deviation is cleared.
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      pos_cmd_q <= 32'h0000_0000;
    end else if (drive_q.dev_clear) begin
      pos_cmd_q <= I_FEEDBACK_POS;
    end else begin
      pos_cmd_q <= pos_cmd_q + I_POS_CMD_STEP;
    end
  end

  assign O_TORQUE_LIMIT = drive_q.torque_limit;
  assign O_FREERUN = drive_q.freerun;
  assign O_DYNAMIC_BRAKING = drive_q.dynamic_braking;
  assign O_DEV_CLEAR = drive_q.dev_clear;
  assign O_ESTOP_DECEL = drive_q.estop_decel;
  assign O_OVERSPEED_FAULT = ovspd_q;
  assign O_OVERLOAD_DET = ovld_q;
  assign O_POS_CMD = pos_cmd_q;

  // An alarm met while running with action seven starts a stop.
  sequence s_alarm_seven;
    I_ALARM && action_q == ACTION_SEVEN && state_q == SPSL_RUN;
  endsequence

  // Deceleration is over once the speed drops under the stop speed.
  sequence s_decel_done;
    state_q == SPSL_DECEL && I_MOTOR_SPEED < SPW'(STOP_SPEED);
  endsequence

  // Thresholds, stop phases and position command checked against the settings.

  a_estop_torque_apply: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    state_q == SPSL_DECEL && estop_torque_limit_q != 16'h0000 && $stable(estop_torque_limit_q)
    |=> O_TORQUE_LIMIT == $past(estop_torque_limit_q))
    else $error("E-stop torque limit not applied.");
  a_estop_zero_normal: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    state_q == SPSL_DECEL && estop_torque_limit_q == 16'h0000
    |=> O_TORQUE_LIMIT == $past(I_NORMAL_TORQUE_LIMIT))
    else $error("Zero e-stop setting did not use normal limit.");
  a_ovld_default: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    overload_level_q == 16'h0000 |-> eff_ovld == OVLD_DEFAULT)
    else $error("Overload default level wrong.");
  a_ovld_clamp: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    I_EFF_TORQUE > OVLD_DEFAULT |=> O_OVERLOAD_DET)
    else $error("Overload above 115 percent missed.");
  a_ovspd_fault: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    I_MOTOR_SPEED > eff_ovspd |=> O_OVERSPEED_FAULT)
    else $error("Over-speed fault not raised.");
  a_ovspd_limit: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    eff_ovspd <= I_MOTOR_OVERSPEED)
    else $error("Over-speed threshold above motor level.");
  a_decel_end: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    state_q == SPSL_DECEL && I_MOTOR_SPEED < SPW'(STOP_SPEED) |=> state_q == SPSL_STOPPED)
    else $error("Deceleration did not end below stop speed.");
  a_estop_sequence: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    s_alarm_seven ##0 I_ALARM_ESTOP |=> ##1 O_ESTOP_DECEL && O_DEV_CLEAR && !O_DYNAMIC_BRAKING)
    else $error("E-stop deceleration not started.");
  a_freerun_sequence: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    s_alarm_seven ##0 !I_ALARM_ESTOP |=> ##1 O_FREERUN && O_DEV_CLEAR && !O_DYNAMIC_BRAKING)
    else $error("Free-run stop not started.");
  a_pos_track: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    O_DEV_CLEAR |=> O_POS_CMD == $past(I_FEEDBACK_POS))
    else $error("Position command not tracking feedback.");

  // The complementary side of the overload and over-speed thresholds, of deceleration and of the position command, and the e-stop torque range.
  a_freerun_after_decel: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    s_decel_done |=> ##1 O_FREERUN && O_DEV_CLEAR && !O_ESTOP_DECEL)
    else $error("Free-run did not follow deceleration.");
  a_cmd_generate: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    !O_DEV_CLEAR |=> O_POS_CMD == $past(O_POS_CMD) + $past(I_POS_CMD_STEP))
    else $error("Position command not advancing.");
  a_ovld_quiet: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    I_EFF_TORQUE <= eff_ovld |=> !O_OVERLOAD_DET)
    else $error("Overload flagged at or below level.");
  a_ovspd_quiet: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    I_MOTOR_SPEED <= eff_ovspd |=> !O_OVERSPEED_FAULT)
    else $error("Over-speed flagged at or below threshold.");
  a_estop_trq_range: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    estop_torque_limit_q <= ESTOP_TRQ_MAX)
    else $error("E-stop torque setting above range.");

endmodule

/* bench/spsl_motor_model.sv */
module spsl_motor_model (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_coast,
  input wire logic i_load,
  input wire logic [15:0] i_load_speed,
  output logic [15:0] o_speed,
  output logic [31:0] o_pos
);
  timeunit 1ns;
  timeprecision 1ns;
  // The rotor keeps its speed while driven and loses a fixed step per cycle when unpowered.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_speed <= 16'h0000;
    end else if (i_load) begin
      o_speed <= i_load_speed;
    end else if (i_coast) begin
      o_speed <= (o_speed > 16'h0040) ? o_speed - 16'h0040 : 16'h0000;
    end
  end
  // The encoder integrates speed, so the position never stands still while turning.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_pos <= 32'h0000_0100;
    end else begin
      o_pos <= o_pos + 32'(o_speed);
    end
  end
endmodule

/* bench/test_servo_protection_stop_logic.sv */
module test_servo_protection_stop_logic;
  import spsl_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_n = 0, awv = 0, wv = 0, brdy = 0, arv = 0, rrdy = 0;
  logic [7:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rd_q, fb, step = 0, pc, d, p;
  logic [1:0] bresp, rresp, r;
  logic awr, wr_r, bv, arr, rv, frun, dbrk, dclr, esd, ovsf, ovld, alm = 0, alme = 0, ld = 0;
  logic [15:0] trq = 0, nrm = 16'h00c8, mos = 16'h1770, lds = 0, tl, spd, v, e;
  int error_cnt = 0, samples_checked = 0, cyc = 0, n;
  // The clock runs at 50 MHz.
  always #10 clk = ~clk;
  spsl_top spsl_top_i (.I_REF_CLK(clk), .I_RST_N(rst_n), .I_AWADDR(awa), .I_AWVALID(awv),
    .O_AWREADY(awr), .I_WDATA(wd), .I_WSTRB(4'hf), .I_WVALID(wv), .O_WREADY(wr_r),
    .O_BRESP(bresp), .O_BVALID(bv), .I_BREADY(brdy), .I_ARADDR(ara), .I_ARVALID(arv),
    .O_ARREADY(arr), .O_RDATA(rd_q), .O_RRESP(rresp), .O_RVALID(rv), .I_RREADY(rrdy),
    .I_MOTOR_SPEED(spd), .I_EFF_TORQUE(trq), .I_NORMAL_TORQUE_LIMIT(nrm),
    .I_MOTOR_OVERSPEED(mos), .I_ALARM(alm), .I_ALARM_ESTOP(alme), .I_FEEDBACK_POS(fb),
    .I_POS_CMD_STEP(step), .O_TORQUE_LIMIT(tl), .O_FREERUN(frun), .O_DYNAMIC_BRAKING(dbrk),
    .O_DEV_CLEAR(dclr), .O_ESTOP_DECEL(esd), .O_OVERSPEED_FAULT(ovsf),
    .O_OVERLOAD_DET(ovld), .O_POS_CMD(pc));
  spsl_motor_model spsl_motor_model_i (.i_clk(clk), .i_rst_n(rst_n), .i_coast(frun | esd),
    .i_load(ld), .i_load_speed(lds), .o_speed(spd), .o_pos(fb));
  // Expected levels follow from the setting and its fallback.
  function automatic logic [15:0] f_ovl(input logic [15:0] s);
    return (s == 0 || s > 16'h0073) ? 16'h0073 : s;
  endfunction
  function automatic logic [15:0] f_ovs(input logic [15:0] s, input logic [15:0] m);
    return (s == 0 || s > m) ? m : s;
  endfunction
  task automatic report_and_stop();
    if (error_cnt == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    samples_checked++;
    if (s !== x) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, x, s);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  // Write cycle: both halves offered together, each released once taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] x);
    logic ta, tw, tb;
    @(posedge clk);
    awa <= a;
    wd <= x;
    awv <= 1'b1;
    wv <= 1'b1;
    brdy <= 1'b1;
    tb = 1'b0;
    while (!tb) begin
      @(negedge clk);
      ta = awv && awr;
      tw = wv && wr_r;
      tb = bv;
      r = bresp;
      @(posedge clk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
    end
    brdy <= 1'b0;
  endtask
  // Read cycle: the address is held until taken, data is taken with rvalid.
  task automatic rdr(input logic [7:0] a);
    logic ta, tr;
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rrdy <= 1'b1;
    tr = 1'b0;
    while (!tr) begin
      @(negedge clk);
      ta = arv && arr;
      tr = rv;
      d = rd_q;
      r = rresp;
      @(posedge clk);
      if (ta) arv <= 1'b0;
    end
    rrdy <= 1'b0;
  endtask
  // A hang is cut short well after the longest sequence.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  initial begin
    void'($urandom(84824));
    tick(4);
    rst_n <= 1'b1;
    step <= $urandom;
    tick(1);
    rdr(ADDR_STATUS);
    chk("status", d, 0);
    rdr(8'h20);
    chk("unmapped resp", r, RESP_SLVERR);
    chk("unmapped data", d, 0);
    wr(ADDR_STATUS, 32'h3);
    chk("read-only resp", r, RESP_SLVERR);
    // Overload level: zero, boundary, above the clamp, range top and random.
    for (int i = 0; i < 5; i++) begin
      v = (i == 0) ? 16'h0 : (i == 1) ? 16'h0073 : (i == 2) ? 16'h0074 : (i == 3) ? 16'h01f4
        : 16'($urandom_range(1, 115));
      e = f_ovl(v);
      wr(ADDR_OVLD_LVL, 32'(v));
      rdr(ADDR_EFF_OVLD);
      chk("overload level", d, 32'(e));
      trq <= e;
      tick(3);
      chk("overload at level", ovld, 0);
      trq <= e + 16'h1;
      tick(3);
      chk("overload above level", ovld, 1);
    end
    trq <= 0;
    // Over-speed level: zero, above the motor, range top and random below.
    mos <= 16'($urandom_range(1000, 19000));
    tick(1);
    for (int i = 0; i < 4; i++) begin
      v = (i == 0) ? 16'h0 : (i == 1) ? mos + 16'h1 : (i == 2) ? OVSPD_MAX
        : 16'($urandom_range(31, mos));
      e = f_ovs(v, mos);
      wr(ADDR_OVSPD_LVL, 32'(v));
      rdr(ADDR_EFF_OVSPD);
      chk("overspeed level", d, 32'(e));
      ld <= 1'b1;
      lds <= e + 16'h1;
      tick(1);
      ld <= 1'b0;
      tick(3);
      chk("overspeed above", ovsf, 1);
      ld <= 1'b1;
      lds <= e;
      tick(1);
      ld <= 1'b0;
      tick(3);
      chk("overspeed at level", ovsf, 0);
    end
    wr(ADDR_ESTOP_TRQ, 32'h258);
    rdr(ADDR_ESTOP_TRQ);
    chk("estop torque range", d, 32'h1f4);
    wr(ADDR_CTRL, 32'(ACTION_SEVEN));
    // Action seven with zero and random estop torque, then a free-run alarm.
    for (int k = 0; k < 3; k++) begin
      v = (k == 0) ? 16'h0 : 16'($urandom_range(1, 500));
      wr(ADDR_ESTOP_TRQ, 32'(v));
      ld <= 1'b1;
      lds <= 16'h0bb8;
      nrm <= 16'($urandom_range(1, 500));
      tick(1);
      ld <= 1'b0;
      alme <= (k != 2);
      alm <= 1'b1;
      tick(3);
      chk("estop decel", esd, k != 2);
      chk("free-run", frun, k == 2);
      chk("braking", dbrk, 0);
      chk("clearing", dclr, 1);
      if (k != 2) chk("torque ceiling", tl, (v == 0) ? nrm : v);
      p = fb;
      tick(1);
      chk("command tracks", pc, p);
      for (n = 0; n < 100 && spd >= STOP_SPEED; n++) tick(1);
      tick(3);
      rdr(ADDR_STATUS);
      chk("post-stop state", d[1:0], 2'h3);
      chk("clear after stop", dclr, 1);
      chk("free-run after stop", frun, 1);
      alm <= 1'b0;
      tick(3);
      chk("clear released", dclr, 0);
      p = pc;
      tick(1);
      chk("command steps", pc, p + step);
    end
    report_and_stop();
  end
endmodule
